// File: design/sprx_map.svh
// Register offsets, field positions, reset values and counts of the receiver settings.
`ifndef SPRX_MAP_SVH
`define SPRX_MAP_SVH
`define SPRX_ADDR_INSEL     8'he8
`define SPRX_ADDR_MISC      8'heb
`define SPRX_INSEL_WMASK    16'hff00
`define SPRX_MISC_WMASK     16'hcddd
`define SPRX_INSEL_RESET    16'h0000
`define SPRX_MISC_RESET     16'h0000
`define SPRX_FRAME_BITS     5'd24
// Input select and error control fields.
`define SPRX_F_PINSEL       9:8
`define SPRX_F_WINDOW       11:10
`define SPRX_F_PARITY       13:12
`define SPRX_B_HOLDLOW      14
`define SPRX_B_HALVE        15
// Miscellaneous control fields.
`define SPRX_B_IDLE         0
`define SPRX_B_RATEFN       2
`define SPRX_B_VALFN        3
`define SPRX_B_CLKINV       4
`define SPRX_B_LOCKPOL      6
`define SPRX_B_XGATE        7
`define SPRX_B_DLYPOL       8
`define SPRX_F_MUTE         11:10
`define SPRX_F_WAIT         15:14
// Preamble B counts for the error-cancel wait codes.
`define SPRX_WAIT_00        6'd48
`define SPRX_WAIT_01        6'd12
`define SPRX_WAIT_10        6'd6
`define SPRX_WAIT_11        6'd3
`define SPRX_PULSE_START    6'd2
`define SPRX_PARITY_LIMIT   4'd8
`endif

// File: design/sprx_pkg.sv
// Types shared by the receiver settings block.
package sprx_pkg;
   typedef enum logic [1:0] {
      SPRX_UNLOCKED = 2'b00,
      SPRX_WAITING  = 2'b01,
      SPRX_LOCKED   = 2'b10
   } sprx_lock_t;
   typedef enum logic [2:0] {
      SPRX_FS_44K1 = 3'b000,
      SPRX_FS_48K  = 3'b001,
      SPRX_FS_32K  = 3'b010,
      SPRX_FS_88K2 = 3'b011,
      SPRX_FS_96K  = 3'b100,
      SPRX_FS_176K = 3'b101,
      SPRX_FS_192K = 3'b110,
      SPRX_FS_NONE = 3'b111
   } sprx_rate_t;
endpackage

// File: design/sprx_settings.sv
// Write-only settings bank and the output steering of the biphase receiver.
`timescale 1ns/1ps
`include "sprx_map.svh"
//==================================================================
// Summary of operation
// - Pin select 01,10,11 routes biphase input a, b, c to receiver.
// - Window field: 00 normal, 01 32-48 kHz, 10 free A, 11 32-96 kHz.
// - Rate outside selected window drives error high even when locked.
// - Parity policy: 00 none, 01 erroneous sub-frame, 11 burst recognition.
// - Policy 00 still conceals erroneous audio data without a flag.
// - Policy 01 suppresses the flag while an output delay is set.
// - Policy 11 recognises bursts only while channel status bit 1 high.
// - Pass-through output follows selected input at 0, held low at 1.
// - Locked with halve bit set, recovered clock runs at half rate.
// - Idle bit sets bus clock idle level: 0 low, 1 high.
// - Rate pins show rate code at 0, delay monitor signals at 1.
// - Validity pin shows validity at 0, second audio copy at 1.
// - Invert bit outputs recovered clock in normal or inverted phase.
// - Lock status idles high at 0 and idles low at 1.
// - Gate bit stops crystal clock while locked if oscillator runs.
// - Lock-status pulse lasts wait count minus two preamble B blocks.
// - Source bit picks digital reception at 0, analog data at 1.
// - Oscillator stops on lock at 0, always runs at 1.
//==================================================================
module sprx_settings
   import sprx_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       nrst,
   // Serial control bus.
   input  wire logic       bus_clock_pin,
   input  wire logic       busData,
   input  wire logic       busEnable,
   // Lower control bits held by the neighbouring register.
   input  wire logic       source_select,
   input  wire logic       oscillator_run_control,
   // Receiver front end.
   input  wire logic       biphase_in_a,
   input  wire logic       biphase_in_b,
   input  wire logic       biphase_in_c,
   input  wire logic       pllLocked,
   input  wire logic [2:0] measuredRate,
   input  wire logic       preambleB,
   input  wire logic       parityError,
   input  wire logic       burstSeen,
   input  wire logic       statusBit1,
   input  wire logic       demodData,
   input  wire logic       analogData,
   input  wire logic       validityFlag,
   input  wire logic       delayActive,
   input  wire logic [1:0] delayState,
   input  wire logic       pllClock,
   input  wire logic       crystalClock,
   // Device pins.
   output logic            receiverIn,
   output logic            passthroughOut,
   output logic            recovered_clock_out,
   output logic            crystal_clock_out,
   output logic            oscillatorEnable,
   output logic            lock_status_out,
   output logic            errorOut,
   output logic            delayed_audio_out,
   output logic            validity_pin,
   output logic [2:0]      ratePins,
   output logic            bus_clock_idle_level
);
   //==================================================================
   // Helpers
   // reception window limits
   function automatic logic rateInWindow(input logic [1:0] win,
                                         input logic [2:0] rate);
      case (win)
         2'b01:   rateInWindow = (rate == SPRX_FS_44K1) ||
                     (rate == SPRX_FS_48K) || (rate == SPRX_FS_32K);
         2'b11:   rateInWindow = (rate != SPRX_FS_176K) &&
                     (rate != SPRX_FS_192K) && (rate != SPRX_FS_NONE);
         default: rateInWindow = 1'b1;
      endcase
   endfunction

   function automatic logic [5:0] waitCount(input logic [1:0] code);
      case (code)
         2'b01:   waitCount = `SPRX_WAIT_01;
         2'b10:   waitCount = `SPRX_WAIT_10;
         2'b11:   waitCount = `SPRX_WAIT_11;
         default: waitCount = `SPRX_WAIT_00;
      endcase
   endfunction

   //==================================================================
   // Serial write port
   logic [15:0] input_select_and_error_control;
   logic [15:0] receiver_misc_control;
   logic [23:0] shiftReg;
   logic [4:0]  bitCount;
   logic        prevBusClk;
   logic        prevEnable;
   logic [15:0] next_inSel;
   logic [15:0] next_misc;
   logic [23:0] next_shiftReg;
   logic [4:0]  next_bitCount;
   logic        shiftEdge;

   always_comb begin
      next_inSel    = input_select_and_error_control;
      next_misc     = receiver_misc_control;
      next_shiftReg = shiftReg;
      next_bitCount = bitCount;
      // Idle level bit picks the edge that leaves the idle level.
      // bus clock idle
      shiftEdge = receiver_misc_control[`SPRX_B_IDLE] ?
                  (prevBusClk && !bus_clock_pin) :
                  (!prevBusClk && bus_clock_pin);
      if (busEnable && shiftEdge && bitCount != `SPRX_FRAME_BITS) begin
         next_shiftReg = {busData, shiftReg[23:1]};
         next_bitCount = bitCount + 5'd1;
      end
      if (!busEnable) begin
         next_bitCount = 5'd0;
      end
      // A frame counts only when all 24 bits arrived by enable release; later bits are ignored.
      if (prevEnable && !busEnable && bitCount == `SPRX_FRAME_BITS) begin
         if (shiftReg[7:0] == `SPRX_ADDR_INSEL) begin
            next_inSel = shiftReg[23:8] & `SPRX_INSEL_WMASK;
         end
         if (shiftReg[7:0] == `SPRX_ADDR_MISC) begin
            next_misc = shiftReg[23:8] & `SPRX_MISC_WMASK;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         input_select_and_error_control <= `SPRX_INSEL_RESET;
         receiver_misc_control          <= `SPRX_MISC_RESET;
         shiftReg                       <= 24'h000000;
         bitCount                       <= 5'd0;
         prevBusClk                     <= 1'b0;
         prevEnable                     <= 1'b0;
      end else begin
         input_select_and_error_control <= next_inSel;
         receiver_misc_control          <= next_misc;
         shiftReg                       <= next_shiftReg;
         bitCount                       <= next_bitCount;
         prevBusClk                     <= bus_clock_pin;
         prevEnable                     <= busEnable;
      end
   end

   //==================================================================
   // Field views
   logic [1:0] pinSel, winSel, parPol, muteSel, waitSel;
   assign pinSel  = input_select_and_error_control[`SPRX_F_PINSEL];
   assign winSel  = input_select_and_error_control[`SPRX_F_WINDOW];
   assign parPol  = input_select_and_error_control[`SPRX_F_PARITY];
   assign muteSel = receiver_misc_control[`SPRX_F_MUTE];
   assign waitSel = receiver_misc_control[`SPRX_F_WAIT];

   //==================================================================
   // Lock tracking and error cancel wait
   sprx_lock_t lockState, next_lockState;
   logic [5:0] pbCount, next_pbCount;
   logic [3:0] parRun, next_parRun;

   always_comb begin
      next_lockState = lockState;
      next_pbCount   = pbCount;
      next_parRun    = parRun;
      if (parityError) begin
         if (parRun != `SPRX_PARITY_LIMIT + 4'd1) begin
            next_parRun = parRun + 4'd1;
         end
      end else if (preambleB) begin
         next_parRun = 4'd0;
      end
      case (lockState)
         SPRX_UNLOCKED: begin
            next_pbCount = 6'd0;
            if (pllLocked) begin
               next_lockState = SPRX_WAITING;
            end
         end
         SPRX_WAITING: begin
            if (preambleB) begin
               next_pbCount = pbCount + 6'd1;
               if (pbCount + 6'd1 == waitCount(waitSel)) begin
                  next_lockState = SPRX_LOCKED;
               end
            end
            if (!pllLocked) begin
               next_lockState = SPRX_UNLOCKED;
            end
         end
         SPRX_LOCKED: begin
            if (!pllLocked) begin
               next_lockState = SPRX_UNLOCKED;
            end
         end
         default: next_lockState = SPRX_UNLOCKED;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lockState <= SPRX_UNLOCKED;
         pbCount   <= 6'd0;
         parRun    <= 4'd0;
      end else begin
         lockState <= next_lockState;
         pbCount   <= next_pbCount;
         parRun    <= next_parRun;
      end
   end

   //==================================================================
   // Output steering
   logic selIn, srcData, parFlag, dataConceal, halfClk, next_halfClk;
   logic prevPllClk, clkSrc, oscRuns, xtalStop, lockPulse, dlyMon;

   always_comb begin
      case (pinSel)
         2'b01:   selIn = biphase_in_a;
         2'b10:   selIn = biphase_in_b;
         2'b11:   selIn = biphase_in_c;
         default: selIn = 1'b0;
      endcase
      srcData = source_select ? analogData : demodData;
      case (parPol)
         2'b01:   parFlag = parityError && !delayActive;
         2'b11:   parFlag = burstSeen && statusBit1;
         default: parFlag = 1'b0;
      endcase
      // Concealment runs under every policy, flagged or not.
      // silent error handling
      dataConceal = parityError && !source_select;
      next_halfClk = halfClk ^ (pllClock && !prevPllClk);
      clkSrc = receiver_misc_control[`SPRX_B_CLKINV] ^
               (input_select_and_error_control[`SPRX_B_HALVE] ?
                halfClk : pllClock);
      oscRuns = oscillator_run_control || lockState == SPRX_UNLOCKED;
      xtalStop = oscillator_run_control && pllLocked &&
                 receiver_misc_control[`SPRX_B_XGATE];
      lockPulse = lockState == SPRX_WAITING &&
                  pbCount >= `SPRX_PULSE_START;
      dlyMon = delayActive ^ receiver_misc_control[`SPRX_B_DLYPOL];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         halfClk              <= 1'b0;
         prevPllClk           <= 1'b0;
         receiverIn           <= 1'b0;
         passthroughOut       <= 1'b0;
         recovered_clock_out  <= 1'b0;
         crystal_clock_out    <= 1'b0;
         oscillatorEnable     <= 1'b1;
         lock_status_out      <= 1'b1;
         errorOut             <= 1'b1;
         delayed_audio_out    <= 1'b0;
         validity_pin         <= 1'b0;
         ratePins             <= 3'h0;
         bus_clock_idle_level <= 1'b0;
      end else begin
         halfClk    <= next_halfClk;
         prevPllClk <= pllClock;
         receiverIn <= selIn && !source_select;
         passthroughOut <= selIn &&
            !input_select_and_error_control[`SPRX_B_HOLDLOW];
         recovered_clock_out <= pllLocked ? clkSrc : 1'b0;
         crystal_clock_out   <= crystalClock && oscRuns && !xtalStop;
         oscillatorEnable    <= oscRuns;
         lock_status_out <= lockPulse ^
            !receiver_misc_control[`SPRX_B_LOCKPOL];
         errorOut <= lockState != SPRX_LOCKED ||
            !rateInWindow(winSel, measuredRate) || parFlag ||
            parRun > `SPRX_PARITY_LIMIT;
         delayed_audio_out <= srcData && !muteSel[0] && !dataConceal;
         validity_pin <= receiver_misc_control[`SPRX_B_VALFN] ?
            (srcData && !muteSel[1] && !dataConceal) : validityFlag;
         ratePins <= receiver_misc_control[`SPRX_B_RATEFN] ?
            {dlyMon, delayState} : measuredRate;
         bus_clock_idle_level <= receiver_misc_control[`SPRX_B_IDLE];
      end
   end

   //==================================================================
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence lockGained;
      !pllLocked ##1 pllLocked;
   endsequence

   a_pin_select_a:
      assert property (pinSel == 2'b01 && !source_select |=>
                       receiverIn == $past(biphase_in_a))
      else $error("input a not routed");
   a_window_error:
      assert property (winSel == 2'b01 && measuredRate == SPRX_FS_96K
                       |=> errorOut)
      else $error("out of window rate without error");
   a_window_free:
      assert property (winSel == 2'b10 && lockState == SPRX_LOCKED &&
                       !parFlag && parRun <= `SPRX_PARITY_LIMIT |=> !errorOut)
      else $error("free mode raised error");
   a_hold_low:
      assert property (input_select_and_error_control[`SPRX_B_HOLDLOW]
                       |=> !passthroughOut)
      else $error("pass-through not held low");
   a_wait_cancel:
      assert property (lockGained ##0 waitSel == 2'b11 &&
                       pllLocked [*8] |-> lockState == SPRX_LOCKED ||
                       $past(pbCount) < 6'd3)
      else $error("error not cancelled after wait");
   a_lock_idle:
      assert property (lockState == SPRX_UNLOCKED &&
                       !receiver_misc_control[`SPRX_B_LOCKPOL]
                       |=> lock_status_out)
      else $error("lock status not idle high");
   a_mute_both:
      assert property (muteSel == 2'b11 |=> !delayed_audio_out &&
                       (!$past(receiver_misc_control[`SPRX_B_VALFN]) ||
                        !validity_pin))
      else $error("muted output carried data");
   a_xtal_gate:
      assert property (xtalStop |=> !crystal_clock_out)
      else $error("crystal clock not gated while locked");
   a_parity_delay:
      assert property (parPol == 2'b01 && delayActive &&
                       lockState == SPRX_LOCKED &&
                       rateInWindow(winSel, measuredRate) &&
                       parRun <= `SPRX_PARITY_LIMIT |=> !errorOut)
      else $error("parity flag under delay");
   a_rate_pins:
      assert property (!receiver_misc_control[`SPRX_B_RATEFN]
                       |=> ratePins == $past(measuredRate))
      else $error("rate pins not showing rate code");
endmodule // sprx_settings

// File: testbench/sprx_host_model.sv
// Host controller model that writes the settings over the serial bus.
`timescale 1ns/1ps
module sprx_host_model (
   // Clock.
   input  wire logic clk,
   // Serial control bus.
   output logic      bus_clock_pin,
   output logic      busData,
   output logic      busEnable
);
   logic idleHigh   = 1'b0;
   int   halfPeriod = 2;

   initial begin
      bus_clock_pin = 1'b0;
      busData       = 1'b0;
      busEnable     = 1'b0;
   end

   //==================================================================
   // Idle level
   // Clock idle follows device.
   task automatic set_idle(input logic level);
      @(posedge clk);
      #1;
      idleHigh      = level;
      bus_clock_pin = level;
   endtask

   //==================================================================
   // Frame writer
   // Address first, then data, each least significant bit first.
   task automatic send(input logic [7:0] addr, input logic [15:0] data,
                       input int nbits = 24);
      logic [23:0] frame;
      frame = {data, addr};
      @(posedge clk);
      #1;
      busEnable = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         busData = frame[i];
         repeat (halfPeriod) @(posedge clk);
         #1;
         bus_clock_pin = !idleHigh;
         repeat (halfPeriod) @(posedge clk);
         #1;
         bus_clock_pin = idleHigh;
      end
      repeat (halfPeriod) @(posedge clk);
      #1;
      busEnable = 1'b0;
      // The line floats once released, so the last bit must not linger.
      busData = !busData;
      repeat (4) @(posedge clk);
      #1;
   endtask
endmodule // sprx_host_model

// File: testbench/sprx_settings_test.sv
// Self-checking bench for the receiver settings block.
`timescale 1ns/1ps
`include "sprx_map.svh"
module sprx_settings_test
   import sprx_pkg::*;
;
   logic clk, nrst, bus_clock_pin, busData, busEnable;
   logic source_select, oscillator_run_control, pllLocked, preambleB;
   logic biphase_in_a, biphase_in_b, biphase_in_c, parityError;
   logic burstSeen, statusBit1, demodData, analogData, validityFlag;
   logic delayActive, pllClock, crystalClock;
   logic [2:0] measuredRate, ratePins;
   logic [1:0] delayState;
   logic receiverIn, passthroughOut, recovered_clock_out;
   logic crystal_clock_out, oscillatorEnable, lock_status_out;
   logic errorOut, delayed_audio_out, validity_pin, bus_clock_idle_level;
   logic [15:0] insel = 16'h0000;
   logic [15:0] misc  = 16'h0000;
   int numErrors = 0;
   int checked   = 0;

   sprx_host_model host (.clk(clk), .bus_clock_pin(bus_clock_pin),
      .busData(busData), .busEnable(busEnable));

   sprx_settings uut (.clk(clk), .nrst(nrst),
      .bus_clock_pin(bus_clock_pin), .busData(busData),
      .busEnable(busEnable), .source_select(source_select),
      .oscillator_run_control(oscillator_run_control),
      .biphase_in_a(biphase_in_a), .biphase_in_b(biphase_in_b),
      .biphase_in_c(biphase_in_c), .pllLocked(pllLocked),
      .measuredRate(measuredRate), .preambleB(preambleB),
      .parityError(parityError), .burstSeen(burstSeen),
      .statusBit1(statusBit1), .demodData(demodData),
      .analogData(analogData), .validityFlag(validityFlag),
      .delayActive(delayActive), .delayState(delayState),
      .pllClock(pllClock), .crystalClock(crystalClock),
      .receiverIn(receiverIn), .passthroughOut(passthroughOut),
      .recovered_clock_out(recovered_clock_out),
      .crystal_clock_out(crystal_clock_out),
      .oscillatorEnable(oscillatorEnable),
      .lock_status_out(lock_status_out), .errorOut(errorOut),
      .delayed_audio_out(delayed_audio_out), .validity_pin(validity_pin),
      .ratePins(ratePins), .bus_clock_idle_level(bus_clock_idle_level));

   //==================================================================
   // Helpers
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      checked++;
      if (got !== exp) begin
         numErrors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic wi();
      host.send(`SPRX_ADDR_INSEL, insel);
   endtask

   task automatic wm();
      host.send(`SPRX_ADDR_MISC, misc);
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   //==================================================================
   // Scenarios
   // Input pin routing.
   task automatic t_route();
      logic [2:0] hot;
      for (int k = 1; k < 4; k++) begin
         hot = 3'(1 << (k - 1));
         insel[`SPRX_F_PINSEL] = 2'(k);
         wi();
         {biphase_in_c, biphase_in_b, biphase_in_a} = hot;
         step(3);
         chk({receiverIn, passthroughOut}, 2'b11, "pin high");
         {biphase_in_c, biphase_in_b, biphase_in_a} = ~hot;
         step(3);
         chk({receiverIn, passthroughOut}, 2'b00, "pin low");
      end
      insel[`SPRX_B_HOLDLOW] = 1'b1;
      wi();
      biphase_in_c = 1'b1;
      step(3);
      chk({receiverIn, passthroughOut}, 2'b10, "held low");
      insel[`SPRX_B_HOLDLOW] = 1'b0;
      wi();
      source_select = 1'b1;
      demodData = 1'b0;
      analogData = 1'b1;
      step(3);
      chk({receiverIn, delayed_audio_out}, 2'b01, "analog");
      source_select = 1'b0;
      demodData = 1'b1;
   endtask

   task automatic t_mute();
      validityFlag = 1'b1;
      step(3);
      chk(validity_pin, validityFlag, "validity flag");
      for (int m = 0; m < 4; m++) begin
         misc[`SPRX_B_VALFN] = 1'b1;
         misc[`SPRX_F_MUTE] = 2'(m);
         wm();
         chk({delayed_audio_out, validity_pin}, {!m[0], !m[1]}, "m");
      end
      misc[`SPRX_F_MUTE] = 2'b00;
   endtask

   task automatic t_rate();
      measuredRate = SPRX_FS_96K;
      step(3);
      chk(ratePins, SPRX_FS_96K, "rate code");
      misc[`SPRX_B_RATEFN] = 1'b1;
      wm();
      chk(ratePins, {1'b0, delayState}, "monitor low");
      misc[`SPRX_B_DLYPOL] = 1'b1;
      wm();
      chk(ratePins, {1'b1, delayState}, "monitor high");
   endtask

   task automatic t_lock();
      int width;
      int waits[4] = '{48, 12, 6, 3};
      measuredRate = SPRX_FS_48K;
      for (int w = 0; w < 4; w++) begin
         misc[`SPRX_F_WAIT] = 2'(w);
         misc[`SPRX_B_LOCKPOL] = w[0];
         wm();
         chk(lock_status_out, !w[0], "lock idle");
         width = 0;
         pllLocked = 1'b1;
         for (int c = 0; c < 8 * (waits[w] + 1); c++) begin
            preambleB = (c % 8 == 7);
            step(1);
            if (lock_status_out === w[0]) width++;
         end
         preambleB = 1'b0;
         chk(16'(width), 16'(8 * (waits[w] - 2)), "pulse");
         chk(errorOut, 1'b0, "error cancelled");
         if (w < 3) begin
            pllLocked = 1'b0;
            step(3);
         end
      end
   endtask

   task automatic t_window();
      logic [1:0] win[5] = '{2'b01, 2'b11, 2'b01, 2'b11, 2'b10};
      sprx_rate_t rt[5] = '{SPRX_FS_48K, SPRX_FS_96K, SPRX_FS_96K,
                            SPRX_FS_192K, SPRX_FS_192K};
      logic [4:0] bad = 5'b01100;
      for (int i = 0; i < 5; i++) begin
         insel[`SPRX_F_WINDOW] = win[i];
         wi();
         measuredRate = rt[i];
         step(3);
         chk(errorOut, 16'(bad[i]), "window error");
      end
   endtask

   task automatic t_parity();
      insel[`SPRX_F_PARITY] = 2'b01;
      wi();
      parityError = 1'b1;
      step(1);
      chk({errorOut, delayed_audio_out}, 2'b10, "flag 01");
      delayActive = 1'b1;
      step(1);
      chk(errorOut, 0, "flag under delay");
      {parityError, delayActive} = 2'b00;
      insel[`SPRX_F_PARITY] = 2'b00;
      wi();
      parityError = 1'b1;
      step(1);
      chk({errorOut, delayed_audio_out}, 2'b00, "silent");
      parityError = 1'b0;
      insel[`SPRX_F_PARITY] = 2'b11;
      wi();
      burstSeen = 1'b1;
      step(1);
      chk(errorOut, 0, "burst no status");
      statusBit1 = 1'b1;
      step(1);
      chk(errorOut, 1, "burst flag");
      {burstSeen, statusBit1} = 2'b00;
      step(2);
      chk(errorOut, 0, "burst gone");
   endtask

   task automatic run_clocks(output int pr, output int xr);
      logic lp, lx;
      pr = 0;
      xr = 0;
      for (int c = 0; c < 64; c++) begin
         lp = recovered_clock_out;
         lx = crystal_clock_out;
         if (c % 2 == 0) begin
            pllClock = !pllClock;
            crystalClock = !crystalClock;
         end
         step(1);
         if (recovered_clock_out === 1'b1 && lp === 1'b0) pr++;
         if (crystal_clock_out === 1'b1 && lx === 1'b0) xr++;
      end
   endtask

   task automatic t_clocks();
      int pr, xr;
      oscillator_run_control = 1'b1;
      misc[`SPRX_B_XGATE] = 1'b1;
      wm();
      run_clocks(pr, xr);
      chk(16'(pr >= 15 && pr <= 17), 1, "full clock");
      chk(16'(xr), 0, "crystal gated");
      insel[`SPRX_B_HALVE] = 1'b1;
      wi();
      run_clocks(pr, xr);
      chk(16'(pr >= 7 && pr <= 9), 1, "halved clock");
      insel[`SPRX_B_HALVE] = 1'b0;
      wi();
      pllClock = 1'b1;
      step(3);
      chk(recovered_clock_out, 1, "normal phase");
      misc[`SPRX_B_CLKINV] = 1'b1;
      wm();
      chk(recovered_clock_out, 0, "inverted phase");
      oscillator_run_control = 1'b0;
      step(3);
      chk(oscillatorEnable, 0, "osc stops");
      oscillator_run_control = 1'b1;
      pllLocked = 1'b0;
      run_clocks(pr, xr);
      chk(16'(xr >= 15 && xr <= 17), 1, "crystal runs");
      chk(oscillatorEnable, 1, "osc runs");
   endtask

   // High idle clock and refused frames.
   task automatic t_bus();
      misc[`SPRX_B_IDLE] = 1'b1;
      misc[`SPRX_B_LOCKPOL] = 1'b0;
      wm();
      chk(bus_clock_idle_level, 1, "idle high");
      host.set_idle(1'b1);
      misc[`SPRX_B_LOCKPOL] = 1'b1;
      wm();
      chk(lock_status_out, 0, "frame at high idle");
      host.send(8'hec, 16'h0001);
      host.send(`SPRX_ADDR_MISC, 16'h0001, 16);
      chk(lock_status_out, 0, "refused frames");
      host.halfPeriod = 5;
      misc[`SPRX_B_LOCKPOL] = 1'b0;
      wm();
      chk(lock_status_out, 1, "slow frame");
   endtask

   //==================================================================
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      // The whole run needs about 4300 cycles; this leaves ample margin.
      #400000;
      numErrors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      nrst = 1'b0;
      {source_select, pllLocked, preambleB, parityError} = 4'h0;
      {burstSeen, statusBit1, demodData, analogData} = 4'h0;
      {validityFlag, delayActive, pllClock, crystalClock} = 4'h0;
      {biphase_in_a, biphase_in_b, biphase_in_c} = 3'h0;
      oscillator_run_control = 1'b0;
      measuredRate = SPRX_FS_48K;
      delayState = 2'b10;
      repeat (16) @(posedge clk);
      #1;
      chk({oscillatorEnable, lock_status_out, errorOut}, 3'h7, "rst");
      chk({receiverIn, passthroughOut, delayed_audio_out, ratePins,
           bus_clock_idle_level}, 0, "reset low");
      nrst = 1'b1;
      step(1);
      t_route();
      t_mute();
      t_rate();
      t_lock();
      t_window();
      t_parity();
      t_clocks();
      t_bus();
      tally_and_finish();
   end
endmodule // sprx_settings_test
